// ==== ppc_pkg.sv ====
/*
 * Constants, register map and types for the ADC post-conversion computation unit.
 * Assumes one clock domain shared with the conversion core and the register port.
 */
package ppc_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int DATA_W = 16;
   localparam int RES_W  = 10;
   localparam int CNT_W  = 8;
   localparam int ADDR_W = 4;

   // ****************************************************************
   // Register word addresses
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_REPEAT  = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_ACC_LO  = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_ACC_HI  = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_COUNT   = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_FILTER  = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_PREV    = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_MASK    = 4'h8;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_SHIFT_LSB = 4;
   localparam int CTRL_DSE_BIT   = 8;
   localparam int CTRL_CAP_BIT   = 9;
   localparam int CTRL_CLEAR_BIT = 12;
   localparam int CTRL_GO_BIT    = 13;

   // ****************************************************************
   // Status register fields (mask uses the same layout)
   // ****************************************************************
   localparam int STAT_DONE_BIT  = 0;
   localparam int STAT_THR_BIT   = 1;
   localparam int STAT_OVF_BIT   = 2;
   localparam int STAT_MATH_BIT  = 3;
   localparam int STAT_BUSY_BIT  = 4;
   localparam int IRQ_W          = 4;
   localparam logic [IRQ_W-1:0] IRQ_W1C_MASK = 4'hb;

   // ****************************************************************
   // Mode codes
   // ****************************************************************
   localparam logic [2:0] MODE_BASIC = 3'h0;
   localparam logic [2:0] MODE_ACCUM = 3'h1;
   localparam logic [2:0] MODE_AVG   = 3'h2;
   localparam logic [2:0] MODE_BURST = 3'h3;
   localparam logic [2:0] MODE_LPF   = 3'h4;

   // ****************************************************************
   // Counts and reset values
   // ****************************************************************
   localparam logic [CNT_W-1:0]  CNT_MAX      = 8'hff;
   localparam logic [CNT_W-1:0]  CNT_ONE      = 8'h01;
   localparam logic [2:0]        CLR_CYCLES   = 3'h5;
   localparam logic [CNT_W-1:0]  REPEAT_RST   = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_WORD    = 16'h0000;

   typedef enum logic {CLR_IDLE, CLR_BUSY} ppc_clr_t;

endpackage

// ==== ppc_adc_compute.sv ====
/*
 * ADC post-conversion computation unit: accumulator, sample counter, filter
 * output, threshold-test event and interrupt, behind a simple register port.
 * Assumes the conversion core runs on ref_clk and gives a one-cycle done pulse
 * with the result beside it; the threshold condition itself is evaluated
 * outside and arrives as a level in the cycle of the done pulse.
 */
// The register offsets and the strobed register port were chosen for this implementation.
module ppc_adc_compute
   import ppc_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWdata,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [DATA_W-1:0] regRdata,
   input  wire logic              convDone,
   input  wire logic [RES_W-1:0]  convResult,
   input  wire logic              convActive,
   input  wire logic              thresholdTrue,
   output logic                   convStart,
   output logic                   extraHoldCapOn,
   output logic                   irq
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic        [2:0]        compModeSel;
   logic        [2:0]        shiftSel;
   logic                     doubleSampleEn;
   logic                     capEnable;
   logic        [CNT_W-1:0]  repeatTarget;
   logic        [IRQ_W-1:0]  irqMask;
   logic signed [DATA_W-1:0] accumulator;
   logic        [CNT_W-1:0]  sampleCount;
   logic        [RES_W-1:0]  prevResult;
   logic                     accOverflow;
   logic                     convDoneFlag;
   logic                     thresholdFlag;
   logic                     mathReady;
   logic                     pairPhase;
   ppc_clr_t                 clrState;
   logic        [2:0]        clrCnt;
   logic                     clrBusy;
   logic                     clrWrite;
   logic                     goWrite;
   logic                     accumMode;
   logic                     restart;
   logic                     firstOfPair;
   logic signed [DATA_W-1:0] sampleVal;
   logic signed [DATA_W-1:0] accBase;
   logic signed [DATA_W:0]   sum17;
   logic                     sumOvf;
   logic        [CNT_W-1:0]  next_count;
   logic                     testNow;
   logic                     thresholdHit;
   logic signed [DATA_W-1:0] filterOutput;
   logic        [IRQ_W-1:0]  statusBits;

   function automatic logic wrHit(input logic [ADDR_W-1:0] off);
      return regWrite && (regAddr == off);
   endfunction

   function automatic logic w1c(input logic [ADDR_W-1:0] off, input int bitPos);
      return wrHit(off) && regWdata[bitPos];
   endfunction

   // ****************************************************************
   // Control registers
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         compModeSel    <= MODE_BASIC;
         shiftSel       <= 3'h0;
         doubleSampleEn <= 1'b0;
         capEnable      <= 1'b0;
      end else if (wrHit(ADDR_CTRL)) begin
         compModeSel    <= regWdata[CTRL_MODE_LSB +: 3];
         shiftSel       <= regWdata[CTRL_SHIFT_LSB +: 3];
         doubleSampleEn <= regWdata[CTRL_DSE_BIT];
         capEnable      <= regWdata[CTRL_CAP_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         repeatTarget <= REPEAT_RST;
      end else if (wrHit(ADDR_REPEAT)) begin
         repeatTarget <= regWdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irqMask <= '0;
      end else if (wrHit(ADDR_MASK)) begin
         irqMask <= regWdata[IRQ_W-1:0];
      end
   end

   assign clrWrite = w1c(ADDR_CTRL, CTRL_CLEAR_BIT);
   assign goWrite  = w1c(ADDR_CTRL, CTRL_GO_BIT);

   // ****************************************************************
   // Accumulator clear sequencer
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clrState <= CLR_IDLE;
         clrCnt   <= 3'h0;
      end else begin
         case (clrState)
            CLR_IDLE: begin
               if (clrWrite) begin
                  clrState <= CLR_BUSY;
                  clrCnt   <= CLR_CYCLES - 3'h1;
               end
            end
            CLR_BUSY: begin
               if (clrCnt == 3'h0) begin
                  clrState <= CLR_IDLE;
               end else begin
                  clrCnt <= clrCnt - 3'h1;
               end
            end
            default: begin
               clrState <= CLR_IDLE;
            end
         endcase
      end
   end

   assign clrBusy = (clrState == CLR_BUSY);

   // ****************************************************************
   // Sample path and arithmetic
   // ****************************************************************
   assign accumMode   = (compModeSel >= MODE_ACCUM) && (compModeSel <= MODE_LPF);
   assign firstOfPair = doubleSampleEn && !pairPhase;
   assign restart     = ((compModeSel == MODE_AVG) || (compModeSel == MODE_BURST))
                        && (sampleCount >= repeatTarget);

   always_comb begin
      if (doubleSampleEn) begin
         sampleVal = $signed({6'h00, convResult}) - $signed({6'h00, prevResult});
      end else begin
         sampleVal = $signed({6'h00, convResult});
      end
   end

   always_comb begin
      if (restart) begin
         accBase = ZERO_WORD;
      end else if (compModeSel == MODE_LPF) begin
         accBase = accumulator - (accumulator >>> shiftSel);
      end else begin
         accBase = accumulator;
      end
   end

   assign sum17  = {accBase[DATA_W-1], accBase} + {sampleVal[DATA_W-1], sampleVal};
   assign sumOvf = sum17[DATA_W] ^ sum17[DATA_W-1];

   always_comb begin
      if (!accumMode) begin
         next_count = sampleCount;
      end else if (restart) begin
         next_count = CNT_ONE;
      end else if (sampleCount == CNT_MAX) begin
         next_count = sampleCount;
      end else begin
         next_count = sampleCount + CNT_ONE;
      end
   end

   // ****************************************************************
   // Accumulator, counter, overflow, previous result
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator <= ZERO_WORD;
      end else if (clrBusy || (goWrite && compModeSel == MODE_BURST)) begin
         accumulator <= ZERO_WORD;
      end else if (convDone && accumMode) begin
         accumulator <= sum17[DATA_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sampleCount <= '0;
      end else if (clrBusy || (goWrite && compModeSel == MODE_BURST)) begin
         sampleCount <= '0;
      end else if (convDone) begin
         sampleCount <= next_count;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         accOverflow <= 1'b0;
      end else if (clrBusy) begin
         accOverflow <= 1'b0;
      end else if (convDone && accumMode && sumOvf) begin
         accOverflow <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prevResult <= '0;
         pairPhase  <= 1'b0;
      end else if (convDone) begin
         prevResult <= convResult;
         pairPhase  <= doubleSampleEn && !pairPhase;
      end else if (!doubleSampleEn) begin
         pairPhase <= 1'b0;
      end
   end

   // ****************************************************************
   // Threshold test and output value
   // ****************************************************************
   assign testNow = convDone && !firstOfPair
                    && (!accumMode || compModeSel == MODE_ACCUM
                        || next_count >= repeatTarget);
   assign thresholdHit = testNow && (thresholdTrue || accOverflow || (accumMode && sumOvf));

   assign filterOutput = (compModeSel == MODE_LPF) ? accumulator
                                                   : (accumulator >>> shiftSel);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         convStart <= 1'b0;
      end else begin
         convStart <= goWrite
                      || (convDone && compModeSel == MODE_BURST && !clrBusy
                          && (firstOfPair || next_count < repeatTarget));
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         extraHoldCapOn <= 1'b0;
      end else begin
         extraHoldCapOn <= capEnable && !convActive;
      end
   end

   // ****************************************************************
   // Sticky status and interrupt
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         convDoneFlag <= 1'b0;
      end else if (convDone) begin
         convDoneFlag <= 1'b1;
      end else if (w1c(ADDR_STATUS, STAT_DONE_BIT)) begin
         convDoneFlag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         thresholdFlag <= 1'b0;
      end else if (thresholdHit) begin
         thresholdFlag <= 1'b1;
      end else if (w1c(ADDR_STATUS, STAT_THR_BIT)) begin
         thresholdFlag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mathReady <= 1'b0;
      end else if (convDone && firstOfPair) begin
         mathReady <= 1'b1;
      end else if (w1c(ADDR_STATUS, STAT_MATH_BIT)) begin
         mathReady <= 1'b0;
      end
   end

   assign statusBits = {mathReady, accOverflow, thresholdFlag, convDoneFlag};

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(statusBits & irqMask);
      end
   end

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdata <= ZERO_WORD;
      end else if (regRead) begin
         case (regAddr)
            ADDR_CTRL: begin
               regRdata <= ZERO_WORD;
               regRdata[CTRL_MODE_LSB +: 3]  <= compModeSel;
               regRdata[CTRL_SHIFT_LSB +: 3] <= shiftSel;
               regRdata[CTRL_DSE_BIT]        <= doubleSampleEn;
               regRdata[CTRL_CAP_BIT]        <= capEnable;
               regRdata[CTRL_CLEAR_BIT]      <= clrBusy;
            end
            ADDR_REPEAT: regRdata <= {8'h00, repeatTarget};
            ADDR_ACC_LO: regRdata <= {8'h00, accumulator[7:0]};
            ADDR_ACC_HI: regRdata <= {8'h00, accumulator[15:8]};
            ADDR_COUNT:  regRdata <= {8'h00, sampleCount};
            ADDR_FILTER: regRdata <= filterOutput;
            ADDR_PREV:   regRdata <= {6'h00, prevResult};
            ADDR_STATUS: regRdata <= {11'h000, clrBusy, statusBits};
            ADDR_MASK:   regRdata <= {12'h000, irqMask};
            default:     regRdata <= ZERO_WORD;
         endcase
      end else begin
         regRdata <= ZERO_WORD;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   clear_zeroes_a: assert property (clrBusy && $past(clrBusy) |->
      accumulator == ZERO_WORD && sampleCount == '0 && !accOverflow)
      else $error("clear did not zero accumulator state");

   clear_length_a: assert property ($rose(clrBusy) |-> clrBusy[*5] ##1 !clrBusy)
      else $error("clear sequence not five cycles");

   basic_hold_a: assert property (convDone && compModeSel == MODE_BASIC && !clrBusy |=>
      $stable(accumulator) && $stable(sampleCount) && convDoneFlag)
      else $error("basic mode changed accumulator");

   accum_sat_a: assert property (convDone && compModeSel == MODE_ACCUM && !clrBusy
      && sampleCount == CNT_MAX |=> sampleCount == CNT_MAX)
      else $error("counter wrapped");

   accum_inc_a: assert property (convDone && compModeSel == MODE_ACCUM && !clrBusy
      && sampleCount != CNT_MAX |=> sampleCount == $past(sampleCount) + CNT_ONE)
      else $error("counter did not increment");

   avg_restart_a: assert property (convDone && compModeSel == MODE_AVG && !clrBusy
      && sampleCount >= repeatTarget |=> sampleCount == CNT_ONE && accumulator == $past(sampleVal))
      else $error("average restart wrong");

   thr_gate_a: assert property (convDone && accumMode && compModeSel != MODE_ACCUM
      && !clrBusy && !goWrite ##1 $rose(thresholdFlag) |-> sampleCount >= $past(repeatTarget))
      else $error("threshold test before target");

   thr_flag_a: assert property ($rose(thresholdFlag) |-> $past(testNow))
      else $error("threshold flag without test");

   burst_retrig_a: assert property (convDone && compModeSel == MODE_BURST && !clrBusy
      && !firstOfPair && next_count < repeatTarget |=> convStart)
      else $error("burst did not retrigger");

   cap_off_a: assert property (convActive |=> !extraHoldCapOn)
      else $error("hold capacitance during conversion");

   pair_first_a: assert property (convDone && firstOfPair |-> !thresholdHit ##1 mathReady)
      else $error("first of pair mishandled");

   ovf_sticky_a: assert property (accOverflow && !clrBusy |=> accOverflow)
      else $error("overflow flag dropped");

   burst_done_c: cover property (compModeSel == MODE_BURST && thresholdHit);
   avg_restart_c: cover property (convDone && compModeSel == MODE_AVG && restart);
   pair_c: cover property (convDone && firstOfPair ##[1:50] convDone && doubleSampleEn);
   ovf_c: cover property ($rose(accOverflow));

endmodule

// ==== ppc_conv_model.sv ====
/*
 * Behavioural conversion core in front of the computation unit.
 * Assumes the unit and this model share ref_clk and rst_n.
 */
module ppc_conv_model
   import ppc_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             convStart,
   input  wire logic             trig,
   input  wire logic [RES_W-1:0] resultIn,
   output logic                  convDone,
   output logic      [RES_W-1:0] convResult,
   output logic                  convActive
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0]       left;
   logic [RES_W-1:0] last;

   // ****************************************************************
   // Three-cycle conversion, result valid only beside done
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         left       <= 3'h0;
         last       <= 10'h000;
         convDone   <= 1'b0;
         convActive <= 1'b0;
         convResult <= 10'h000;
      end else begin
         convDone   <= 1'b0;
         convResult <= ~last;
         if (left != 3'h0) begin
            left <= left - 3'h1;
            if (left == 3'h1) begin
               convActive <= 1'b0;
               convDone   <= 1'b1;
               convResult <= resultIn;
               last       <= resultIn;
            end
         end else if (convStart || trig) begin
            left       <= 3'h3;
            convActive <= 1'b1;
         end
      end
   end
endmodule

// ==== tb_adc_post_conversion_computation.sv ====
/*
 * Self-checking bench for the computation unit with a conversion core model.
 * Assumes the register map and status layout of ppc_pkg.
 */
module tb_adc_post_conversion_computation
   import ppc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              ref_clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [ADDR_W-1:0] regAddr = 4'h0;
   logic [DATA_W-1:0] regWdata = 16'h0000;
   logic              regWrite = 1'b0;
   logic              regRead = 1'b0;
   logic [DATA_W-1:0] regRdata;
   logic              convDone;
   logic [RES_W-1:0]  convResult;
   logic              convActive;
   logic              thresholdTrue = 1'b0;
   logic              convStart;
   logic              extraHoldCapOn;
   logic              irq;
   logic              trig = 1'b0;
   logic [RES_W-1:0]  resIn = 10'h000;
   int                failures = 0;
   int                checks_done = 0;
   logic [DATA_W-1:0] d;

   ppc_adc_compute uut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .convDone(convDone),
      .convResult(convResult), .convActive(convActive), .thresholdTrue(thresholdTrue),
      .convStart(convStart), .extraHoldCapOn(extraHoldCapOn), .irq(irq));
   ppc_conv_model core (.ref_clk(ref_clk), .rst_n(rst_n), .convStart(convStart), .trig(trig),
      .resultIn(resIn), .convDone(convDone), .convResult(convResult), .convActive(convActive));

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic end_sim();
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= v;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(posedge ref_clk);
      d = regRdata;
   endtask

   task automatic conv(input logic [RES_W-1:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      trig  <= 1'b1;
      resIn <= r;
      @(posedge ref_clk);
      trig <= 1'b0;
      while (convDone !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 20) begin
         failures++;
      end
   endtask

   function automatic logic [DATA_W-1:0] cw(input logic [2:0] m, input logic [2:0] s, input logic ds);
      return {7'h00, ds, 1'b0, s, 1'b0, m};
   endfunction

   // Clear with a mode, then drop all sticky flags
   task automatic clr(input logic [DATA_W-1:0] c);
      wr(ADDR_CTRL, c | 16'h1000);
      rd(ADDR_STATUS);
      chk("busy", d & 16'h0010, 16'h0010);
      repeat (5) @(posedge ref_clk);
      rd(ADDR_STATUS);
      chk("idle", d & 16'h0010, 16'h0000);
      wr(ADDR_STATUS, 16'h000b);
   endtask

   task automatic expect_acc(input logic [DATA_W-1:0] acc, input logic [DATA_W-1:0] cnt);
      rd(ADDR_ACC_LO);
      chk("accLo", d, {8'h00, acc[7:0]});
      rd(ADDR_ACC_HI);
      chk("accHi", d, {8'h00, acc[15:8]});
      rd(ADDR_COUNT);
      chk("count", d, cnt);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      rd(ADDR_CTRL);
      chk("ctrl", d, 16'h0000);
      rd(ADDR_STATUS);
      chk("status", d, 16'h0000);
      rd(4'h9);
      chk("unmapped", d, 16'h0000);
      chk("irq", {15'h0, irq}, 16'h0000);
   endtask

   task automatic t_accum();
      clr(cw(MODE_ACCUM, 3'h1, 1'b0));
      conv(10'h005);
      conv(10'h007);
      expect_acc(16'h000c, 16'h0002);
      rd(ADDR_FILTER);
      chk("filter", d, 16'h0006);
      rd(ADDR_STATUS);
      chk("thrOff", d & 16'h0002, 16'h0000);
      thresholdTrue <= 1'b1;
      conv(10'h001);
      rd(ADDR_FILTER);
      chk("floor", d, 16'h0006);
      rd(ADDR_STATUS);
      chk("thrOn", d & 16'h0003, 16'h0003);
      thresholdTrue <= 1'b0;
   endtask

   task automatic t_avg();
      wr(ADDR_REPEAT, 16'h0002);
      clr(cw(MODE_AVG, 3'h0, 1'b0));
      thresholdTrue <= 1'b1;
      conv(10'h003);
      rd(ADDR_STATUS);
      chk("avgEarly", d & 16'h0002, 16'h0000);
      conv(10'h004);
      expect_acc(16'h0007, 16'h0002);
      rd(ADDR_STATUS);
      chk("avgTest", d & 16'h0002, 16'h0002);
      conv(10'h00a);
      expect_acc(16'h000a, 16'h0001);
      thresholdTrue <= 1'b0;
   endtask

   task automatic t_burst();
      wr(ADDR_REPEAT, 16'h0003);
      clr(cw(MODE_BURST, 3'h0, 1'b0));
      resIn <= 10'h002;
      wr(ADDR_CTRL, cw(MODE_BURST, 3'h0, 1'b0) | 16'h2000);
      repeat (40) @(posedge ref_clk);
      expect_acc(16'h0006, 16'h0003);
   endtask

   task automatic t_lpf_basic();
      clr(cw(MODE_LPF, 3'h1, 1'b0));
      conv(10'h008);
      conv(10'h008);
      expect_acc(16'h000c, 16'h0002);
      rd(ADDR_FILTER);
      chk("lpfOut", d, 16'h000c);
      wr(ADDR_CTRL, cw(MODE_BASIC, 3'h1, 1'b0));
      wr(ADDR_STATUS, 16'h000b);
      conv(10'h009);
      expect_acc(16'h000c, 16'h0002);
      rd(ADDR_STATUS);
      chk("basicDone", d & 16'h0001, 16'h0001);
   endtask

   task automatic t_double();
      clr(cw(MODE_ACCUM, 3'h0, 1'b1));
      thresholdTrue <= 1'b1;
      conv(10'h00a);
      rd(ADDR_STATUS);
      chk("firstPair", d & 16'h000a, 16'h0008);
      conv(10'h004);
      rd(ADDR_STATUS);
      chk("secondPair", d & 16'h0002, 16'h0002);
      expect_acc(16'hfffb, 16'h0002);
      thresholdTrue <= 1'b0;
   endtask

   task automatic t_irq_cap();
      wr(ADDR_STATUS, 16'h000b);
      wr(ADDR_MASK, 16'h0001);
      conv(10'h001);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irqHigh", {15'h0, irq}, 16'h0001);
      wr(ADDR_STATUS, 16'h0001);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("irqLow", {15'h0, irq}, 16'h0000);
      wr(ADDR_CTRL, 16'h0200);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("capIdle", {15'h0, extraHoldCapOn}, 16'h0001);
      @(posedge ref_clk);
      trig <= 1'b1;
      @(posedge ref_clk);
      trig <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("capConv", {15'h0, extraHoldCapOn}, 16'h0000);
   endtask

   task automatic t_sat_ovf();
      clr(cw(MODE_ACCUM, 3'h0, 1'b0));
      for (int i = 0; i < 256; i++) begin
         conv(10'h000);
      end
      expect_acc(16'h0000, 16'h00ff);
      for (int i = 0; i < 33; i++) begin
         conv(10'h3ff);
      end
      rd(ADDR_STATUS);
      chk("ovf", d & 16'h0004, 16'h0004);
      clr(cw(MODE_ACCUM, 3'h0, 1'b0));
      rd(ADDR_STATUS);
      chk("ovfClr", d & 16'h0004, 16'h0000);
      expect_acc(16'h0000, 16'h0000);
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_accum();
      t_avg();
      t_burst();
      t_lpf_basic();
      t_double();
      t_irq_cap();
      t_sat_ovf();
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      end_sim();
   end
endmodule
